//--- hdl/dbgpr_regs.sv
module dbgpr_regs #(
  parameter logic [7:0] PART_IDENTITY = 8'h5a,  // arbitrary value
  parameter logic [7:0] SILICON_REV   = 8'h01   // arbitrary value
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        debug_clock_pin,
  input  wire logic        debug_data_pin_in,
  output logic             debug_data_pin_out,
  output logic             debug_data_pin_oe,
  output logic [15:0]      prog_address,
  output logic [7:0]       mem_wdata,
  output logic             mem_write_req,
  output logic             mem_read_req,
  input  wire logic        mem_done,
  input  wire logic        mem_refused,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        write_protected_flag,
  input  wire logic        read_protected_flag,
  output logic             crc_start,
  output logic [15:0]      crc_start_addr,
  input  wire logic        crc_done,
  input  wire logic [15:0] crc_result,
  output logic [7:0]       device_halt_control,
  output logic [7:0]       prog_enable_control
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dbgpr_pkg::dbgpr_link_t link_reg;
  dbgpr_pkg::dbgpr_link_t link_next;
  dbgpr_pkg::dbgpr_core_t core_reg;
  dbgpr_pkg::dbgpr_core_t core_next;
  logic [7:0]             status_val;
  logic                   go;
  logic                   ok_to_launch;

  function automatic logic [7:0] reg_read(input logic [7:0] sel,
                                          input dbgpr_pkg::dbgpr_core_t c,
                                          input logic [7:0] stat);
    logic [7:0] v;
    v = dbgpr_pkg::RESET_BYTE;
    case (sel)
      dbgpr_pkg::SEL_PART_IDENTITY:  v = PART_IDENTITY;
      dbgpr_pkg::SEL_SILICON_REV:    v = SILICON_REV;
      dbgpr_pkg::SEL_HALT_CONTROL:   v = c.halt;
      dbgpr_pkg::SEL_BLOCK_BLOCK_CRC_BYTE0:     v = c.block_crc_byte0;
      dbgpr_pkg::SEL_BLOCK_BLOCK_CRC_BYTE1:     v = c.block_crc_byte1;
      dbgpr_pkg::SEL_PROG_ADDR_LOW:  v = c.addr_lo;
      dbgpr_pkg::SEL_PROG_ADDR_HIGH: v = c.addr_hi;
      dbgpr_pkg::SEL_PROG_STATUS:    v = stat;
      dbgpr_pkg::SEL_PROG_DATA:      v = c.data;
      dbgpr_pkg::SEL_PROG_ENABLE:    v = c.enable;
      default:                       v = dbgpr_pkg::RESET_BYTE;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // link side, on the programmer's clock
  // ----------------------------------------------------------------
  always_comb
  begin
    link_next        = link_reg;
    link_next.ack_s1 = core_reg.ack_tgl;
    link_next.ack_s2 = link_reg.ack_s1;
    case (link_reg.state)
      dbgpr_pkg::DBGPR_IDLE:
      begin
        link_next.pin_oe = 1'b0;
        if (!debug_data_pin_in)
        begin
          link_next.state = dbgpr_pkg::DBGPR_CMD;
          link_next.cnt   = 4'h0;
        end
      end
      dbgpr_pkg::DBGPR_CMD:
      begin
        link_next.cmd[link_reg.cnt[0]] = debug_data_pin_in;
        link_next.cnt = link_reg.cnt + 4'h1;
        if (link_reg.cnt == dbgpr_pkg::CMD_LAST_BIT)
        begin
          link_next.cnt = 4'h0;
          if (link_reg.cmd[0])
          begin
            link_next.state = dbgpr_pkg::DBGPR_DATA;
          end
          else
          begin
            link_next.state   = dbgpr_pkg::DBGPR_WAIT;
            link_next.req_tgl = ~link_reg.req_tgl;
            link_next.pin_oe  = 1'b1;
            link_next.pin_out = 1'b0;
          end
        end
      end
      dbgpr_pkg::DBGPR_DATA:
      begin
        link_next.shreg[link_reg.cnt[2:0]] = debug_data_pin_in;
        link_next.cnt = link_reg.cnt + 4'h1;
        if (link_reg.cnt == dbgpr_pkg::DATA_LAST_BIT)
        begin
          link_next.state   = dbgpr_pkg::DBGPR_WAIT;
          link_next.req_tgl = ~link_reg.req_tgl;
          link_next.pin_oe  = 1'b1;
          link_next.pin_out = 1'b0;
        end
      end
      dbgpr_pkg::DBGPR_WAIT:
      begin
        // reply stays stable in the core until the next request toggle
        if (link_reg.ack_s2 == link_reg.req_tgl)
        begin
          link_next.state   = dbgpr_pkg::DBGPR_REPLY;
          link_next.pin_out = 1'b1;
          link_next.shreg   = core_reg.reply;
          link_next.cnt     = 4'h0;
        end
      end
      dbgpr_pkg::DBGPR_REPLY:
      begin
        if (link_reg.cmd[0] || link_reg.cnt == dbgpr_pkg::REPLY_BITS)
        begin
          link_next.state  = dbgpr_pkg::DBGPR_IDLE;
          link_next.pin_oe = 1'b0;
        end
        else
        begin
          link_next.pin_out = link_reg.shreg[link_reg.cnt[2:0]];
          link_next.cnt     = link_reg.cnt + 4'h1;
        end
      end
      default:
      begin
        link_next.state  = dbgpr_pkg::DBGPR_IDLE;
        link_next.pin_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge debug_clock_pin or posedge reset)
  begin
    if (reset)
    begin
      link_reg <= '{state: dbgpr_pkg::DBGPR_IDLE, default: '0};
    end
    else
    begin
      link_reg <= link_next;
    end
  end

  // single data line, driven only while answering
  assign debug_data_pin_out = link_reg.pin_out;
  assign debug_data_pin_oe  = link_reg.pin_oe;

  // ----------------------------------------------------------------
  // register bank, on the system clock
  // ----------------------------------------------------------------
  // status assembled from the live lock flags and the held error flag
  always_comb
  begin
    status_val = dbgpr_pkg::RESET_BYTE;
    status_val[dbgpr_pkg::STAT_WR_LOCK_BIT] = write_protected_flag;
    status_val[dbgpr_pkg::STAT_RD_LOCK_BIT] = read_protected_flag;
    status_val[dbgpr_pkg::STAT_ERROR_BIT]   = core_reg.err;
  end

  assign go           = core_reg.req_s2 ^ core_reg.req_s3;
  // memory access only while halted and enabled
  assign ok_to_launch = (core_reg.halt != dbgpr_pkg::RESET_BYTE) &&
                        (core_reg.enable != dbgpr_pkg::RESET_BYTE) && !core_reg.mem_busy;

  always_comb
  begin
    core_next        = core_reg;
    core_next.req_s1 = link_reg.req_tgl;
    core_next.req_s2 = core_reg.req_s1;
    core_next.req_s3 = core_reg.req_s2;
    core_next.mem_wr = 1'b0;
    core_next.mem_rd = 1'b0;
    core_next.crc_go = 1'b0;
    // outcome of the last access decides the error flag
    if (mem_done && core_reg.mem_busy)
    begin
      core_next.mem_busy = 1'b0;
      core_next.err      = mem_refused;
      if (core_reg.mem_is_rd && !mem_refused)
      begin
        core_next.data = mem_rdata;
      end
    end
    // result lands only when the engine finishes
    if (crc_done && core_reg.crc_busy)
    begin
      core_next.crc_busy = 1'b0;
      core_next.block_crc_byte1     = crc_result[15:8];
      core_next.block_crc_byte0     = crc_result[7:0];
    end
    if (go)
    begin
      core_next.ack_tgl = ~core_reg.ack_tgl;
      core_next.reply   = dbgpr_pkg::RESET_BYTE;
      case (link_reg.cmd)
        dbgpr_pkg::CMD_ADDR_WRITE: core_next.sel = link_reg.shreg;
        dbgpr_pkg::CMD_ADDR_READ:
        begin
          // busy covers memory and crc work
          core_next.reply[dbgpr_pkg::PORT_BUSY_BIT] = core_reg.mem_busy | core_reg.crc_busy;
        end
        dbgpr_pkg::CMD_DATA_WRITE:
        begin
          // identity, revision and status have no write path
          case (core_reg.sel)
            dbgpr_pkg::SEL_HALT_CONTROL:   core_next.halt    = link_reg.shreg;
            dbgpr_pkg::SEL_PROG_ENABLE:    core_next.enable  = link_reg.shreg;
            dbgpr_pkg::SEL_PROG_ADDR_HIGH: core_next.addr_hi = link_reg.shreg;
            dbgpr_pkg::SEL_PROG_ADDR_LOW:  core_next.addr_lo = link_reg.shreg;
            dbgpr_pkg::SEL_PROG_DATA:
            begin
              core_next.data = link_reg.shreg;
              if (ok_to_launch)
              begin
                core_next.mem_wr    = 1'b1;
                core_next.mem_busy  = 1'b1;
                core_next.mem_is_rd = 1'b0;
              end
            end
            dbgpr_pkg::SEL_BLOCK_BLOCK_CRC_BYTE0:
            begin
              // start page held in block_crc_byte0 until the result
              if (!core_reg.crc_busy)
              begin
                core_next.block_crc_byte0     = link_reg.shreg;
                core_next.crc_go   = 1'b1;
                core_next.crc_busy = 1'b1;
              end
            end
            default: core_next.sel = core_reg.sel;
          endcase
        end
        default:
        begin
          core_next.reply = reg_read(core_reg.sel, core_reg, status_val);
          // reading data returns the held byte and fetches the next
          if (core_reg.sel == dbgpr_pkg::SEL_PROG_DATA && ok_to_launch)
          begin
            core_next.mem_rd    = 1'b1;
            core_next.mem_busy  = 1'b1;
            core_next.mem_is_rd = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      core_reg <= '0;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  assign prog_address        = {core_reg.addr_hi, core_reg.addr_lo};
  assign mem_wdata           = core_reg.data;
  assign mem_write_req       = core_reg.mem_wr;
  assign mem_read_req        = core_reg.mem_rd;
  assign crc_start           = core_reg.crc_go;
  assign crc_start_addr      = {core_reg.block_crc_byte0, dbgpr_pkg::CRC_BLOCK_LOW};
  assign device_halt_control = core_reg.halt;
  assign prog_enable_control = core_reg.enable;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_status_unused_zero: assert property (@(posedge sys_clk) disable iff (reset)
    go && link_reg.cmd == dbgpr_pkg::CMD_DATA_READ && core_reg.sel == dbgpr_pkg::SEL_PROG_STATUS
    |=> core_reg.reply[5:1] == 5'h00) else $error("unused status bits not zero");
  a_write_protected_flag_follows: assert property (@(posedge sys_clk) disable iff (reset)
    go && link_reg.cmd == dbgpr_pkg::CMD_DATA_READ && core_reg.sel == dbgpr_pkg::SEL_PROG_STATUS
    |=> core_reg.reply[7] == $past(write_protected_flag)) else $error("write lock bit wrong");
  a_read_protected_flag_follows: assert property (@(posedge sys_clk) disable iff (reset)
    go && link_reg.cmd == dbgpr_pkg::CMD_DATA_READ && core_reg.sel == dbgpr_pkg::SEL_PROG_STATUS
    |=> core_reg.reply[6] == $past(read_protected_flag)) else $error("read lock bit wrong");
  a_crc_page_align: assert property (@(posedge sys_clk) disable iff (reset)
    crc_start |-> crc_start_addr[7:0] == 8'h00 && crc_start_addr[15:8] == $past(link_reg.shreg))
    else $error("crc start address wrong");
  a_crc_result_load: assert property (@(posedge sys_clk) disable iff (reset)
    crc_done && core_reg.crc_busy |=> core_reg.block_crc_byte1 == $past(crc_result[15:8]) &&
                                      core_reg.block_crc_byte0 == $past(crc_result[7:0]))
    else $error("crc result not loaded");
  a_crc_hold_busy: assert property (@(posedge sys_clk) disable iff (reset)
    core_reg.crc_busy && !crc_done |=> $stable(core_reg.block_crc_byte1) && core_reg.crc_busy)
    else $error("crc result changed while busy");
  a_error_on_refuse: assert property (@(posedge sys_clk) disable iff (reset)
    mem_done && core_reg.mem_busy |=> core_reg.err == $past(mem_refused) && !core_reg.mem_busy)
    else $error("error flag not updated");
  a_write_launch: assert property (@(posedge sys_clk) disable iff (reset)
    mem_write_req |-> mem_wdata == $past(link_reg.shreg) && core_reg.mem_busy &&
                      core_reg.halt != 8'h00 && core_reg.enable != 8'h00)
    else $error("memory write launched wrongly");
  a_idle_release: assert property (@(posedge debug_clock_pin) disable iff (reset)
    link_reg.state == dbgpr_pkg::DBGPR_IDLE |-> !debug_data_pin_oe ##1 1'b1)
    else $error("data pin driven while idle");

endmodule // dbgpr_regs

//--- common/dbgpr_pkg.sv
package dbgpr_pkg;

  // ----------------------------------------------------------------
  // register selections on the debug port
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_PART_IDENTITY  = 8'h00;
  localparam logic [7:0] SEL_SILICON_REV    = 8'h01;
  localparam logic [7:0] SEL_HALT_CONTROL   = 8'h02;
  localparam logic [7:0] SEL_BLOCK_BLOCK_CRC_BYTE0     = 8'ha9;
  localparam logic [7:0] SEL_BLOCK_BLOCK_CRC_BYTE1     = 8'haa;
  localparam logic [7:0] SEL_PROG_ADDR_LOW  = 8'hae;
  localparam logic [7:0] SEL_PROG_ADDR_HIGH = 8'haf;
  localparam logic [7:0] SEL_PROG_STATUS    = 8'hb7;
  localparam logic [7:0] SEL_PROG_DATA      = 8'hbf;
  localparam logic [7:0] SEL_PROG_ENABLE    = 8'hdf;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE        = 8'h00;
  localparam int         STAT_WR_LOCK_BIT  = 7;
  localparam int         STAT_RD_LOCK_BIT  = 6;
  localparam int         STAT_ERROR_BIT    = 0;
  localparam int         PORT_BUSY_BIT     = 0;
  localparam logic [7:0] CRC_BLOCK_LOW     = 8'h00;

  // ----------------------------------------------------------------
  // link framing: command bit 0 = write, bit 1 = address register
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_DATA_READ  = 2'h0;
  localparam logic [1:0] CMD_DATA_WRITE = 2'h1;
  localparam logic [1:0] CMD_ADDR_READ  = 2'h2;
  localparam logic [1:0] CMD_ADDR_WRITE = 2'h3;
  localparam logic [3:0] CMD_LAST_BIT   = 4'h1;
  localparam logic [3:0] DATA_LAST_BIT  = 4'h7;
  localparam logic [3:0] REPLY_BITS     = 4'h8;

  typedef enum logic [4:0] {
    DBGPR_IDLE  = 5'b00001,
    DBGPR_CMD   = 5'b00010,
    DBGPR_DATA  = 5'b00100,
    DBGPR_WAIT  = 5'b01000,
    DBGPR_REPLY = 5'b10000
  } dbgpr_link_state_t;

  typedef struct packed {
    dbgpr_link_state_t state;
    logic [3:0]        cnt;
    logic [1:0]        cmd;
    logic [7:0]        shreg;
    logic              req_tgl;
    logic              ack_s1;
    logic              ack_s2;
    logic              pin_out;
    logic              pin_oe;
  } dbgpr_link_t;

  typedef struct packed {
    logic       req_s1;
    logic       req_s2;
    logic       req_s3;
    logic       ack_tgl;
    logic [7:0] reply;
    logic [7:0] sel;
    logic [7:0] halt;
    logic [7:0] enable;
    logic [7:0] data;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic       err;
    logic [7:0] block_crc_byte0;
    logic [7:0] block_crc_byte1;
    logic       mem_busy;
    logic       mem_is_rd;
    logic       crc_busy;
    logic       mem_wr;
    logic       mem_rd;
    logic       crc_go;
  } dbgpr_core_t;

endpackage

//--- verif/dbgpr_host_model.sv
module dbgpr_host_model (
  output logic      debug_clock_pin,
  output logic      host_oe,
  output logic      host_val,
  input  wire logic line,
  input  wire logic dev_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    debug_clock_pin = 1'b0;
    host_oe = 1'b0;
    host_val = 1'b1;
  end

  // clock driven by host
  // clock stands still between frames; data moves 11 ns after each rise
  task automatic tick();
    #4 debug_clock_pin <= 1'b1;
    #7.5 debug_clock_pin <= 1'b0;
    #3.5;
  endtask

  task automatic xfer(input logic [1:0] cmd, input logic [7:0] wd, output logic [7:0] rd, output logic ok);
    int n;
    ok = 1'b1;
    rd = 8'h00;
    host_oe <= 1'b0;
    tick();
    tick();
    host_oe <= 1'b1;
    host_val <= 1'b0;
    tick();
    host_val <= cmd[0];
    tick();
    host_val <= cmd[1];
    tick();
    if (cmd[0])
      for (n = 0; n < 8; n++)
      begin
        host_val <= wd[n];
        tick();
      end
    host_oe <= 1'b0;
    if (!(dev_oe && !line))
      ok = 1'b0;
    n = 0;
    while (!(dev_oe && line) && n < 40)
    begin
      tick();
      n++;
    end
    if (n >= 40)
      ok = 1'b0;
    if (!cmd[0])
      for (n = 0; n < 8; n++)
      begin
        tick();
        rd[n] = line;
      end
    tick();
    if (dev_oe)
      ok = 1'b0;
  endtask
endmodule // dbgpr_host_model

//--- verif/debug_port_prom_program_regs_tb.sv
module debug_port_prom_program_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        ck, hoe, hval, line, p_out, p_oe;
  logic [15:0] prog_address, crc_start_addr, crc_seen;
  logic [7:0]  mem_wdata, halt, enab, v;
  logic        mem_write_req, mem_read_req, crc_start;
  logic        mem_done = 1'b0;
  logic        mem_refused = 1'b0;
  logic [7:0]  mem_rdata = 8'h00;
  logic        wp = 1'b0;
  logic        rp = 1'b0;
  logic        crc_done = 1'b0;
  logic [15:0] crc_result = 16'h0000;
  logic        m_wr = 1'b0;
  logic [7:0]  mem_arr [0:255];
  logic [7:0]  tbl [0:7] = '{8'h02, 8'hdf, 8'hbf, 8'hae, 8'haf, 8'hb7, 8'ha9, 8'haa};
  logic [7:0]  ro [0:3] = '{8'h00, 8'h01, 8'hb7, 8'h55};
  logic [7:0]  ro_e [0:3] = '{8'ha5, 8'h03, 8'h00, 8'h00};
  int          mcnt = 0;
  int          ccnt = 0;
  int          n_wreq = 0;
  int          n_mismatch = 0;
  int          n_compared = 0;

  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end

  // pull-up on the data line when nobody drives it
  assign line = p_oe ? p_out : (hoe ? hval : 1'b1);

  dbgpr_host_model host (.debug_clock_pin(ck), .host_oe(hoe), .host_val(hval), .line(line), .dev_oe(p_oe));

  dbgpr_regs #(.PART_IDENTITY(8'ha5), .SILICON_REV(8'h03)) dut (  // arbitrary values
    .sys_clk(sys_clk), .reset(reset), .debug_clock_pin(ck), .debug_data_pin_in(line),
    .debug_data_pin_out(p_out), .debug_data_pin_oe(p_oe), .prog_address(prog_address),
    .mem_wdata(mem_wdata), .mem_write_req(mem_write_req), .mem_read_req(mem_read_req),
    .mem_done(mem_done), .mem_refused(mem_refused), .mem_rdata(mem_rdata),
    .write_protected_flag(wp), .read_protected_flag(rp), .crc_start(crc_start),
    .crc_start_addr(crc_start_addr), .crc_done(crc_done), .crc_result(crc_result),
    .device_halt_control(halt), .prog_enable_control(enab));

  // ----------------------------------------------------------------
  // memory and crc engine model
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    mem_done <= 1'b0;
    crc_done <= 1'b0;
    wp <= (prog_address[15:8] == 8'hf0);
    rp <= (prog_address[15:8] == 8'hf1);
    if (mem_write_req || mem_read_req)
    begin
      mcnt <= 5;
      m_wr <= mem_write_req;
      n_wreq <= n_wreq + int'(mem_write_req);
    end
    else if (mcnt > 0)
    begin
      mcnt <= mcnt - 1;
      mem_done <= (mcnt == 1);
      mem_refused <= m_wr ? wp : rp;
      mem_rdata <= mem_arr[prog_address[7:0]];
      if (mcnt == 1 && m_wr && !wp)
        mem_arr[prog_address[7:0]] <= mem_wdata;
    end
    if (crc_start)
    begin
      ccnt <= 60;
      crc_seen <= crc_start_addr;
    end
    else if (ccnt > 0)
    begin
      ccnt <= ccnt - 1;
      crc_done <= (ccnt == 1);
      crc_result <= {crc_seen[15:8] ^ 8'h5e, 8'hb1};
    end
  end

  // ----------------------------------------------------------------
  // compare, report and access tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic xf(input logic [1:0] c, input logic [7:0] w, output logic [7:0] r);
    logic ok;
    host.xfer(c, w, r, ok);
    chk8("frame", 8'h01, {7'h00, ok});
    if (!ok)
      final_report();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    xf(dbgpr_pkg::CMD_ADDR_WRITE, a, r);
    xf(dbgpr_pkg::CMD_DATA_WRITE, d, r);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    xf(dbgpr_pkg::CMD_ADDR_WRITE, a, r);
    xf(dbgpr_pkg::CMD_DATA_READ, 8'h00, r);
    chk8(nm, e, r);
  endtask

  task automatic idle_wait();
    logic [7:0] s;
    int         n;
    s = 8'h01;
    for (n = 0; n < 30 && s !== 8'h00; n++)
      xf(dbgpr_pkg::CMD_ADDR_READ, 8'h00, s);
    chk8("busy_clear", 8'h00, s);
    if (s !== 8'h00)
      final_report();
  endtask

  initial
  begin
    mem_arr[8'h20] = 8'hc3;
    fork
      begin
        host.tick();
        host.tick();
      end
      repeat (3) @(posedge sys_clk);
    join
    reset <= 1'b0;
    xf(dbgpr_pkg::CMD_DATA_READ, 8'h00, v);
    chk8("select_reset", 8'ha5, v);
    for (int i = 0; i < 8; i++)
      rc("reset_value", tbl[i], 8'h00);
    rc("revision", dbgpr_pkg::SEL_SILICON_REV, 8'h03);
    for (int i = 0; i < 4; i++)
      wr(ro[i], 8'hff);
    for (int i = 0; i < 4; i++)
      rc("read_only", ro[i], ro_e[i]);
    // launch needs both halt and enable
    wr(dbgpr_pkg::SEL_PROG_ENABLE, 8'h01);
    wr(dbgpr_pkg::SEL_PROG_DATA, 8'h11);
    chk8("no_launch", 8'h00, 8'(n_wreq));
    wr(dbgpr_pkg::SEL_HALT_CONTROL, 8'h01);
    wr(dbgpr_pkg::SEL_PROG_ADDR_LOW, 8'h10);
    chk8("halt_port", 8'h01, halt);
    chk8("enable_port", 8'h01, enab);
    chk16("address", 16'h0010, prog_address);
    wr(dbgpr_pkg::SEL_PROG_DATA, 8'h77);
    idle_wait();
    chk8("launches", 8'h01, 8'(n_wreq));
    chk8("mem_written", 8'h77, mem_arr[8'h10]);
    wr(dbgpr_pkg::SEL_PROG_ADDR_LOW, 8'h20);
    rc("data_old", dbgpr_pkg::SEL_PROG_DATA, 8'h77);
    idle_wait();
    rc("data_read", dbgpr_pkg::SEL_PROG_DATA, 8'hc3);
    idle_wait();
    // refused accesses set the error bit
    wr(dbgpr_pkg::SEL_PROG_ADDR_HIGH, 8'hf0);
    rc("stat_wlock", dbgpr_pkg::SEL_PROG_STATUS, 8'h80);
    wr(dbgpr_pkg::SEL_PROG_DATA, 8'h5a);
    idle_wait();
    rc("stat_werr", dbgpr_pkg::SEL_PROG_STATUS, 8'h81);
    chk8("refused_no_write", 8'hc3, mem_arr[8'h20]);
    wr(dbgpr_pkg::SEL_PROG_ADDR_HIGH, 8'hf1);
    rc("data_rd", dbgpr_pkg::SEL_PROG_DATA, 8'h5a);
    idle_wait();
    rc("stat_rerr", dbgpr_pkg::SEL_PROG_STATUS, 8'h41);
    wr(dbgpr_pkg::SEL_PROG_ADDR_HIGH, 8'h00);
    rc("stat_keep", dbgpr_pkg::SEL_PROG_STATUS, 8'h01);
    wr(dbgpr_pkg::SEL_PROG_DATA, 8'h66);
    idle_wait();
    rc("stat_clear", dbgpr_pkg::SEL_PROG_STATUS, 8'h00);
    // block crc
    wr(dbgpr_pkg::SEL_BLOCK_BLOCK_CRC_BYTE0, 8'h12);
    xf(dbgpr_pkg::CMD_ADDR_READ, 8'h00, v);
    chk8("crc_busy", 8'h01, v);
    rc("block_crc_byte1_hold", dbgpr_pkg::SEL_BLOCK_BLOCK_CRC_BYTE1, 8'h00);
    idle_wait();
    chk16("crc_start", 16'h1200, crc_seen);
    rc("block_crc_byte1", dbgpr_pkg::SEL_BLOCK_BLOCK_CRC_BYTE1, 8'h4c);
    rc("block_crc_byte0", dbgpr_pkg::SEL_BLOCK_BLOCK_CRC_BYTE0, 8'hb1);
    final_report();
  end
endmodule // debug_port_prom_program_regs_tb
